// [logic/nvsc_pkg.sv]
// constants for the host-side controller of a store/recall backed async sram
// assumes a 125 MHz clock; device times are held in ns and turned into cycle counts here
package nvsc_pkg;
  localparam int CLK_NS = 8;
  // device timings in ns (plain defaults, tune for the fitted part)
  localparam int ACCESS_NS = 45;
  localparam int STORE_REQUEST_DELAY_NS = 25;
  localparam int STORE_CYCLE_TIME_NS = 8000000;
  localparam int SOFT_RECALL_TIME_NS = 200000;
  localparam int POWERUP_RECALL_TIME_NS = 20000000;
  localparam int BUSY_TO_OUTPUT_ACTIVE_NS = 5;
  // least times round up to whole cycles
  localparam int SYNC_CYC = 2;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int GAP_CYC = 2;
  localparam int STORE_REQUEST_DELAY_CYC = (STORE_REQUEST_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_CYCLE_CYC = (STORE_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SOFT_RECALL_CYC = (SOFT_RECALL_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int POWERUP_RECALL_CYC = (POWERUP_RECALL_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_TO_OUTPUT_ACTIVE_CYC = (BUSY_TO_OUTPUT_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 22;
  // pin widths (x16 organisation)
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  // software sequence addresses (only bits 14..2 are decoded by the device)
  localparam logic [15:0] SEQ_A0 = 16'h4E38;
  localparam logic [15:0] SEQ_A1 = 16'hB1C7;
  localparam logic [15:0] SEQ_A2 = 16'h83E0;
  localparam logic [15:0] SEQ_A3 = 16'h7C1F;
  localparam logic [15:0] SEQ_A4 = 16'h703F;
  localparam logic [15:0] SEQ_STORE = 16'h8FC0;
  localparam logic [15:0] SEQ_RECALL = 16'h4C63;
  localparam logic [15:0] SEQ_AS_OFF = 16'h8B45;
  localparam logic [15:0] SEQ_AS_ON = 16'h4B46;
  localparam logic [2:0] SEQ_LAST = 3'h5;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // command codes written to REG_CMD[2:0]
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_HW_STORE = 3'h3;
  localparam logic [2:0] CMD_SW_STORE = 3'h4;
  localparam logic [2:0] CMD_SW_RECALL = 3'h5;
  localparam logic [2:0] CMD_AS_OFF = 3'h6;
  localparam logic [2:0] CMD_AS_ON = 3'h7;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_PIN = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_CORE_PG = 4;
  localparam int ST_IO_PG = 5;
  localparam int ST_DONE = 6;
  // wdata layout: data in 15:0, byte enables (active high) in 17:16
  localparam int WD_BE_LO = 16;
  localparam int WD_BE_HI = 17;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_PWRUP, ST_PWRWAIT, ST_IDLE, ST_ACC, ST_SEQ_ON, ST_SEQ_OFF,
    ST_HWREQ, ST_NVWAIT, ST_PINWAIT, ST_SETTLE
  } nvsc_state_type;
endpackage

// [logic/nvsc_sync.sv]
// two flip-flop synchroniser, one chain per bit
// assumes inputs are asynchronous to clk_i; the first stage feeds only the second
`timescale 1ns/1ps
module nvsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // every stage resets to zero, so a synced level reads low until the second edge after reset
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= async_i[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_ff;
endmodule

// [logic/nvsc_ctrl.sv]
// host-side controller for an async sram with store/recall and a store-busy handshake pin
// assumes: software reaches registers over a plain strobe port; the pin is open drain with
// a pull-up outside; core/io power-good come from board supervisors, asynchronous to clk_i
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module nvsc_ctrl #(
  parameter int STORE_CYCLE_CYC = nvsc_pkg::STORE_CYCLE_CYC,
  parameter int SOFT_RECALL_CYC = nvsc_pkg::SOFT_RECALL_CYC,
  parameter int POWERUP_RECALL_CYC = nvsc_pkg::POWERUP_RECALL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic core_pwr_good_i,
  input wire logic io_pwr_good_i,
  output logic chip_select_n_o,
  output logic output_enable_n_o,
  output logic write_enable_n_o,
  output logic upper_byte_enable_n_o,
  output logic lower_byte_enable_n_o,
  output logic [nvsc_pkg::ADDR_W-1:0] addr_o,
  input wire logic [nvsc_pkg::DATA_W-1:0] dq_i,
  output logic [nvsc_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic store_busy_handshake_i,
  output logic store_busy_handshake_o,
  output logic store_busy_handshake_oe_o
);
  localparam int SW = 3 + nvsc_pkg::DATA_W;
  localparam logic [nvsc_pkg::TMR_W-1:0] ACC_T = nvsc_pkg::TMR_W'(nvsc_pkg::ACCESS_CYC - 1);
  localparam logic [nvsc_pkg::TMR_W-1:0] GAP_T = nvsc_pkg::TMR_W'(nvsc_pkg::GAP_CYC - 1);
  localparam logic [nvsc_pkg::TMR_W-1:0] REQ_T = nvsc_pkg::TMR_W'(nvsc_pkg::STORE_REQUEST_DELAY_CYC - 1);
  localparam logic [nvsc_pkg::TMR_W-1:0] LZ_T = nvsc_pkg::TMR_W'(nvsc_pkg::BUSY_TO_OUTPUT_ACTIVE_CYC - 1);
  localparam logic [nvsc_pkg::TMR_W-1:0] ST_T = nvsc_pkg::TMR_W'(STORE_CYCLE_CYC - 1);
  localparam logic [nvsc_pkg::TMR_W-1:0] RC_T = nvsc_pkg::TMR_W'(SOFT_RECALL_CYC - 1);
  localparam logic [nvsc_pkg::TMR_W-1:0] PU_T = nvsc_pkg::TMR_W'(POWERUP_RECALL_CYC - 1);
  localparam logic [nvsc_pkg::TMR_W-1:0] T_ZERO = '0;

  logic [SW-1:0] sync_w;
  logic core_pg;
  logic io_pg;
  logic pin_high;
  logic [nvsc_pkg::DATA_W-1:0] dq_s;

  // power-good, busy pin and data bus all come from outside the clock domain
  nvsc_sync #(.WIDTH(SW)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({core_pwr_good_i, io_pwr_good_i, store_busy_handshake_i, dq_i}),
    .sync_o(sync_w)
  );
  assign core_pg = sync_w[SW-1];
  assign io_pg = sync_w[SW-2];
  assign pin_high = sync_w[SW-3];
  assign dq_s = sync_w[nvsc_pkg::DATA_W-1:0];

  nvsc_pkg::nvsc_state_type state_ff, nxt_state;
  logic [nvsc_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;
  logic [2:0] cmd_ff, nxt_cmd;
  logic [2:0] seq_ff, nxt_seq;
  logic [nvsc_pkg::ADDR_W-1:0] addr_reg_ff, nxt_addr_reg;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [nvsc_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic refused_ff, nxt_refused;
  logic done_ff, nxt_done;
  logic [31:0] rd_ff, nxt_rd;
  logic ce_n_ff, nxt_ce_n;
  logic oe_n_ff, nxt_oe_n;
  logic we_n_ff, nxt_we_n;
  logic ub_n_ff, nxt_ub_n;
  logic lb_n_ff, nxt_lb_n;
  logic [nvsc_pkg::ADDR_W-1:0] pin_addr_ff, nxt_pin_addr;
  logic [nvsc_pkg::DATA_W-1:0] dq_ff, nxt_dq;
  logic dq_oe_ff, nxt_dq_oe;
  logic busy_oe_ff, nxt_busy_oe;
  logic cmd_wr;
  logic [15:0] seq_addr;

  assign cmd_wr = reg_wr_i && (reg_addr_i == nvsc_pkg::REG_CMD);

  // address of the current sequence read; the sixth depends on the command
  always_comb begin
    seq_addr = nvsc_pkg::SEQ_A0;
    unique case (seq_ff)
      3'h0: seq_addr = nvsc_pkg::SEQ_A0;
      3'h1: seq_addr = nvsc_pkg::SEQ_A1;
      3'h2: seq_addr = nvsc_pkg::SEQ_A2;
      3'h3: seq_addr = nvsc_pkg::SEQ_A3;
      3'h4: seq_addr = nvsc_pkg::SEQ_A4;
      default: begin
        unique case (cmd_ff)
          nvsc_pkg::CMD_SW_STORE: seq_addr = nvsc_pkg::SEQ_STORE;
          nvsc_pkg::CMD_SW_RECALL: seq_addr = nvsc_pkg::SEQ_RECALL;
          nvsc_pkg::CMD_AS_OFF: seq_addr = nvsc_pkg::SEQ_AS_OFF;
          default: seq_addr = nvsc_pkg::SEQ_AS_ON;
        endcase
      end
    endcase
  end

  // controller state, pin drive and register file next values
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = (tmr_ff == T_ZERO) ? T_ZERO : tmr_ff - 1'b1;
    nxt_cmd = cmd_ff;
    nxt_seq = seq_ff;
    nxt_addr_reg = addr_reg_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_refused = refused_ff;
    nxt_done = done_ff;
    nxt_ce_n = ce_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_we_n = we_n_ff;
    nxt_ub_n = ub_n_ff;
    nxt_lb_n = lb_n_ff;
    nxt_pin_addr = pin_addr_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_busy_oe = busy_oe_ff;
    nxt_rd = rd_ff;
    // register writes; a software clear loses to a hardware set in the same cycle
    if (reg_wr_i && reg_addr_i == nvsc_pkg::REG_ADDR) begin
      nxt_addr_reg = reg_wdata_i[nvsc_pkg::ADDR_W-1:0];
    end
    if (reg_wr_i && reg_addr_i == nvsc_pkg::REG_WDATA) begin
      nxt_wdata = reg_wdata_i;
    end
    if (cmd_wr) begin
      nxt_refused = 1'b0;
      nxt_done = 1'b0;
    end
    unique case (state_ff)
      nvsc_pkg::ST_PWRUP: begin
        // we_n stays high so no write is presented while the device recalls
        if (core_pg && io_pg) begin
          nxt_tmr = PU_T;
          nxt_state = nvsc_pkg::ST_PWRWAIT;
        end
      end
      nvsc_pkg::ST_PWRWAIT: begin
        if (!core_pg || !io_pg) begin
          nxt_state = nvsc_pkg::ST_PWRUP;
        end else if (tmr_ff == T_ZERO && pin_high) begin
          nxt_tmr = LZ_T;
          nxt_state = nvsc_pkg::ST_SETTLE;
        end
      end
      nvsc_pkg::ST_IDLE: begin
        if (!core_pg || !io_pg) begin
          // a core dip means an automatic save and later a recall on the device side
          nxt_state = nvsc_pkg::ST_PWRUP;
        end
        if (cmd_wr) begin
          nxt_cmd = reg_wdata_i[2:0];
          nxt_seq = 3'h0;
          if (!core_pg || !io_pg || !pin_high || reg_wdata_i[2:0] == 3'h0) begin
            nxt_refused = 1'b1;
          end else if (reg_wdata_i[2:0] == nvsc_pkg::CMD_READ || reg_wdata_i[2:0] == nvsc_pkg::CMD_WRITE) begin
            nxt_pin_addr = addr_reg_ff;
            nxt_ce_n = 1'b0;
            nxt_oe_n = (reg_wdata_i[2:0] == nvsc_pkg::CMD_WRITE);
            nxt_we_n = (reg_wdata_i[2:0] != nvsc_pkg::CMD_WRITE);
            nxt_dq_oe = (reg_wdata_i[2:0] == nvsc_pkg::CMD_WRITE);
            nxt_dq = wdata_ff[nvsc_pkg::DATA_W-1:0];
            nxt_ub_n = !wdata_ff[nvsc_pkg::WD_BE_HI];
            nxt_lb_n = !wdata_ff[nvsc_pkg::WD_BE_LO];
            nxt_tmr = ACC_T;
            nxt_state = nvsc_pkg::ST_ACC;
          end else if (reg_wdata_i[2:0] == nvsc_pkg::CMD_HW_STORE) begin
            nxt_busy_oe = 1'b1;
            nxt_tmr = REQ_T;
            nxt_state = nvsc_pkg::ST_HWREQ;
          end else begin
            nxt_state = nvsc_pkg::ST_SEQ_OFF;
            nxt_tmr = T_ZERO;
          end
        end
      end
      nvsc_pkg::ST_ACC: begin
        if (tmr_ff == T_ZERO) begin
          if (!oe_n_ff) begin
            nxt_rdata = dq_s;
          end
          nxt_ce_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_we_n = 1'b1;
          nxt_dq_oe = 1'b0;
          nxt_done = 1'b1;
          nxt_state = nvsc_pkg::ST_IDLE;
        end
      end
      nvsc_pkg::ST_SEQ_OFF: begin
        // the sequence owns the bus until it ends, so nothing can interleave
        if (tmr_ff == T_ZERO) begin
          nxt_pin_addr = {{(nvsc_pkg::ADDR_W-16){1'b0}}, seq_addr};
          nxt_ce_n = 1'b0;
          nxt_oe_n = 1'b0;
          nxt_we_n = 1'b1;
          nxt_ub_n = 1'b0;
          nxt_lb_n = 1'b0;
          nxt_tmr = ACC_T;
          nxt_state = nvsc_pkg::ST_SEQ_ON;
        end
      end
      nvsc_pkg::ST_SEQ_ON: begin
        if (tmr_ff == T_ZERO) begin
          nxt_ce_n = 1'b1;
          nxt_oe_n = 1'b1;
          if (seq_ff == 3'h0) begin
            nxt_rdata = dq_s;
          end
          if (seq_ff != nvsc_pkg::SEQ_LAST) begin
            nxt_seq = seq_ff + 3'h1;
            nxt_tmr = GAP_T;
            nxt_state = nvsc_pkg::ST_SEQ_OFF;
          end else if (cmd_ff == nvsc_pkg::CMD_SW_STORE) begin
            nxt_tmr = ST_T;
            nxt_state = nvsc_pkg::ST_NVWAIT;
          end else if (cmd_ff == nvsc_pkg::CMD_SW_RECALL) begin
            nxt_tmr = RC_T;
            nxt_state = nvsc_pkg::ST_NVWAIT;
          end else begin
            // a new automatic save setting is lost at power-down unless stored, so store it at once
            nxt_cmd = nvsc_pkg::CMD_SW_STORE;
            nxt_seq = 3'h0;
            nxt_tmr = GAP_T;
            nxt_state = nvsc_pkg::ST_SEQ_OFF;
          end
        end
      end
      nvsc_pkg::ST_HWREQ: begin
        // hold the request through the delay so writes in flight can finish
        if (tmr_ff == T_ZERO) begin
          nxt_busy_oe = 1'b0;
          nxt_tmr = T_ZERO;
          nxt_state = nvsc_pkg::ST_PINWAIT;
        end
      end
      nvsc_pkg::ST_NVWAIT: begin
        if (tmr_ff == T_ZERO) begin
          nxt_state = nvsc_pkg::ST_PINWAIT;
        end
      end
      nvsc_pkg::ST_PINWAIT: begin
        // device holds the pin low while storing; access waits until it is high
        if (pin_high) begin
          nxt_tmr = LZ_T;
          nxt_state = nvsc_pkg::ST_SETTLE;
        end
      end
      nvsc_pkg::ST_SETTLE: begin
        if (tmr_ff == T_ZERO) begin
          nxt_done = 1'b1;
          nxt_state = nvsc_pkg::ST_IDLE;
        end
      end
    endcase
    // read data stands the cycle after the strobe only
    nxt_rd = nvsc_pkg::RESET_WORD;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        nvsc_pkg::REG_ADDR: nxt_rd = 32'(addr_reg_ff);
        nvsc_pkg::REG_WDATA: nxt_rd = wdata_ff;
        nvsc_pkg::REG_RDATA: nxt_rd = 32'(rdata_ff);
        nvsc_pkg::REG_STATUS: begin
          nxt_rd[nvsc_pkg::ST_BUSY] = (state_ff != nvsc_pkg::ST_IDLE);
          nxt_rd[nvsc_pkg::ST_READY] = (state_ff == nvsc_pkg::ST_IDLE) && pin_high;
          nxt_rd[nvsc_pkg::ST_PIN] = pin_high;
          nxt_rd[nvsc_pkg::ST_REFUSED] = refused_ff;
          nxt_rd[nvsc_pkg::ST_CORE_PG] = core_pg;
          nxt_rd[nvsc_pkg::ST_IO_PG] = io_pg;
          nxt_rd[nvsc_pkg::ST_DONE] = done_ff;
        end
        default: nxt_rd = nvsc_pkg::RESET_WORD;
      endcase
    end
    // a command written while busy is dropped and flagged
    if (cmd_wr && state_ff != nvsc_pkg::ST_IDLE) begin
      nxt_refused = 1'b1;
    end
  end

  // registers only; the pins idle deselected with the bus released
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= nvsc_pkg::ST_PWRUP;
      tmr_ff <= '0;
      cmd_ff <= 3'h0;
      seq_ff <= 3'h0;
      addr_reg_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      rdata_ff <= '0;
      refused_ff <= 1'b0;
      done_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      ce_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      ub_n_ff <= 1'b1;
      lb_n_ff <= 1'b1;
      pin_addr_ff <= '0;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      busy_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      cmd_ff <= nxt_cmd;
      seq_ff <= nxt_seq;
      addr_reg_ff <= nxt_addr_reg;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      refused_ff <= nxt_refused;
      done_ff <= nxt_done;
      rd_ff <= nxt_rd;
      ce_n_ff <= nxt_ce_n;
      oe_n_ff <= nxt_oe_n;
      we_n_ff <= nxt_we_n;
      ub_n_ff <= nxt_ub_n;
      lb_n_ff <= nxt_lb_n;
      pin_addr_ff <= nxt_pin_addr;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      busy_oe_ff <= nxt_busy_oe;
    end
  end

  // open drain: the pin is only ever pulled low, never driven high by the host
  assign store_busy_handshake_o = 1'b0;
  assign store_busy_handshake_oe_o = busy_oe_ff;
  assign reg_rdata_o = rd_ff;
  assign chip_select_n_o = ce_n_ff;
  assign output_enable_n_o = oe_n_ff;
  assign write_enable_n_o = we_n_ff;
  assign upper_byte_enable_n_o = ub_n_ff;
  assign lower_byte_enable_n_o = lb_n_ff;
  assign addr_o = pin_addr_ff;
  assign dq_o = dq_ff;
  assign dq_oe_o = dq_oe_ff;
endmodule

// [verif/nvsc_ctrl_sva.sv]
// pin-level checker for the store/recall host controller
// assumes it is bound onto nvsc_ctrl and shares its single clock
`timescale 1ns/1ps
module nvsc_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic core_pwr_good_i,
  input wire logic chip_select_n_o,
  input wire logic output_enable_n_o,
  input wire logic write_enable_n_o,
  input wire logic store_busy_handshake_i,
  input wire logic store_busy_handshake_o,
  input wire logic store_busy_handshake_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // host pull spans the request delay, then lets go
  sequence s_pull;
    store_busy_handshake_oe_o [*4] ##1 !store_busy_handshake_oe_o;
  endsequence
  // one access keeps chip select low for the whole access time
  sequence s_acc;
    !chip_select_n_o [*8] ##1 chip_select_n_o;
  endsequence
  a_pull_len: assert property ($rose(store_busy_handshake_oe_o) |-> s_pull)
    else $error("busy pull length wrong");
  a_pull_quiet: assert property (store_busy_handshake_oe_o |-> chip_select_n_o)
    else $error("access while pulling busy");
  a_acc_len: assert property ($fell(chip_select_n_o) |-> s_acc)
    else $error("access length wrong");
  a_acc_gap: assert property ($rose(chip_select_n_o) |-> chip_select_n_o [*2])
    else $error("accesses not framed by chip select");
  a_read_we_high: assert property (!output_enable_n_o |-> write_enable_n_o && !chip_select_n_o)
    else $error("read with write enable low");
  a_pin_low_idle: assert property (!store_busy_handshake_i [*4] |-> chip_select_n_o)
    else $error("access while busy pin low");
  a_core_low_idle: assert property (!core_pwr_good_i [*4] |-> chip_select_n_o)
    else $error("access while core power low");
  a_pin_open_drain: assert property (store_busy_handshake_oe_o |-> !store_busy_handshake_o)
    else $error("busy pin driven high");
endmodule
bind nvsc_ctrl nvsc_ctrl_sva u_sva (.*);

// [verif/nvsc_dev.sv]
// device model: sram with store/recall, busy pin and sequence decoder
// assumes sampling on the bench clock; busy pin pulled up outside
`timescale 1ns/1ps
module nvsc_dev #(
  parameter int SC = 30,
  parameter int RC = 30,
  parameter int PR = 20,
  parameter int DLY = 2
) (
  input wire logic clk_i,
  input wire logic core_pg_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [1:0] be_n_i,
  input wire logic [17:0] addr_i,
  input wire logic [15:0] wd_i,
  input wire logic pin_i,
  output logic [15:0] rd_o,
  output logic low_o,
  output int stores,
  output int recalls,
  output logic as_en
);
  logic [15:0] mem[int];
  logic [15:0] nv[int];
  logic [15:0] seq[5] = '{nvsc_pkg::SEQ_A0, nvsc_pkg::SEQ_A1, nvsc_pkg::SEQ_A2, nvsc_pkg::SEQ_A3, nvsc_pkg::SEQ_A4};
  logic [17:0] pa;
  logic [15:0] pd, old;
  logic [1:0] pbe;
  logic pcs = 1'b1, pwe = 1'b1, pcore = 1'b0, ppin = 1'b1, wl = 1'b0;
  int cnt = 0, dcnt = 0, idx = 0;
  initial begin
    stores = 0;
    recalls = 0;
    rd_o = 16'h0000;
    as_en = 1'b1;
  end
  // decode looks at address bits 14..2 only
  function automatic logic hit(input logic [17:0] a, input logic [15:0] s);
    return a[14:2] == s[14:2];
  endfunction
  function automatic logic [15:0] rdm(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction
  task automatic do_store;
    nv = mem;
    stores++;
    wl = 1'b0;
    cnt = SC;
  endtask
  // released pin goes high through the pull-up
  assign low_o = cnt > 0;
  // accesses act when chip select rises; a floating bus toggles every cycle
  always @(posedge clk_i) begin
    rd_o <= (!cs_n_i && !oe_n_i && we_n_i && cnt == 0) ? rdm(addr_i) : ~rd_o;
    {pcs, pwe, pcore, ppin, pa, pd, pbe} <= {cs_n_i, we_n_i, core_pg_i, pin_i, addr_i, wd_i, be_n_i};
    if (!core_pg_i && pcore && as_en && wl) do_store();
    if (core_pg_i && !pcore) begin
      mem = nv;
      recalls++;
      wl = 1'b0;
      cnt = PR;
    end else if (cnt > 0) begin
      cnt--;
    end else if (core_pg_i && cs_n_i && !pcs && !pwe) begin
      old = rdm(pa);
      mem[pa] = {pbe[1] ? old[15:8] : pd[15:8], pbe[0] ? old[7:0] : pd[7:0]};
      wl = 1'b1;
      idx = 0;
    end else if (core_pg_i && cs_n_i && !pcs) begin
      if (idx < 5 && hit(pa, seq[idx])) idx++;
      else if (idx == 5 && hit(pa, nvsc_pkg::SEQ_STORE)) do_store();
      else if (idx == 5 && hit(pa, nvsc_pkg::SEQ_RECALL)) begin
        mem = nv;
        recalls++;
        wl = 1'b0;
        cnt = RC;
      end
      else if (idx == 5 && hit(pa, nvsc_pkg::SEQ_AS_OFF)) as_en = 1'b0;
      else if (idx == 5 && hit(pa, nvsc_pkg::SEQ_AS_ON)) as_en = 1'b1;
      if (cnt > 0 || !hit(pa, seq[idx == 0 ? 0 : idx - 1])) idx = hit(pa, seq[0]) ? 1 : 0;
      if (idx > 5) idx = 0;
    end
    // hardware request: store only if something was written
    if (!pin_i && ppin && cnt == 0) dcnt = DLY;
    else if (dcnt > 0) begin
      dcnt--;
      if (dcnt == 0 && wl) do_store();
    end
  end
endmodule

// [verif/nonvolatile_store_recall_control_tb_top.sv]
// self-checking bench for the store/recall host controller
// assumes the device model in nvsc_dev and the bound checker
`timescale 1ns/1ps
module nonvolatile_store_recall_control_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, cpg = 1'b0, iopg = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdat, q;
  logic cs, oe, we, ub, lb, doe, bo, boe, dlow, aen;
  logic [17:0] a, ad;
  logic [15:0] dqo, drd;
  logic [15:0] tm[int];
  logic [15:0] tn[int];
  int num_errors = 0, checks = 0, st, rc, i, es = 0, er = 1;
  // open-drain busy line with pull-up; data bus owned by whoever enables
  wire pin = !(boe || dlow);
  wire [15:0] bus = doe ? dqo : drd;
  always #4 clk_i = ~clk_i;
  nvsc_ctrl #(.STORE_CYCLE_CYC(20), .SOFT_RECALL_CYC(20), .POWERUP_RECALL_CYC(20)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .core_pwr_good_i(cpg), .io_pwr_good_i(iopg), .chip_select_n_o(cs),
    .output_enable_n_o(oe), .write_enable_n_o(we), .upper_byte_enable_n_o(ub), .lower_byte_enable_n_o(lb),
    .addr_o(a), .dq_i(bus), .dq_o(dqo), .dq_oe_o(doe), .store_busy_handshake_i(pin),
    .store_busy_handshake_o(bo), .store_busy_handshake_oe_o(boe));
  nvsc_dev u_dev (.clk_i(clk_i), .core_pg_i(cpg), .cs_n_i(cs), .oe_n_i(oe), .we_n_i(we), .be_n_i({ub, lb}),
    .addr_i(a), .wd_i(bus), .pin_i(pin), .rd_o(drd), .low_o(dlow), .stores(st), .recalls(rc), .as_en(aen));
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // register strobes last one cycle; read data taken in the cycle after
  task automatic wreg(input logic [7:0] ad_r, input logic [31:0] d);
    @(posedge clk_i);
    {wr, ra, wd} <= {1'b1, ad_r, d};
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad_r, output logic [31:0] d);
    @(posedge clk_i);
    {rd, ra} <= {1'b1, ad_r};
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // bounded wait for a status bit; running out ends the run
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 2000; n++) begin
      rreg(nvsc_pkg::REG_STATUS, q);
      if (q[b] === 1'b1) break;
    end
    if (n == 2000) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic cmd(input logic [2:0] c);
    wreg(nvsc_pkg::REG_CMD, {29'h0, c});
    poll(nvsc_pkg::ST_DONE);
  endtask
  // reference memory follows the byte enables
  task automatic swr(input logic [17:0] ad_w, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] o;
    o = tm.exists(ad_w) ? tm[ad_w] : 16'h0000;
    wreg(nvsc_pkg::REG_ADDR, {14'h0, ad_w});
    wreg(nvsc_pkg::REG_WDATA, {14'h0, be, d});
    cmd(nvsc_pkg::CMD_WRITE);
    tm[ad_w] = {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endtask
  task automatic srd(input logic [17:0] ad_w);
    wreg(nvsc_pkg::REG_ADDR, {14'h0, ad_w});
    cmd(nvsc_pkg::CMD_READ);
    rreg(nvsc_pkg::REG_RDATA, q);
    chk(q, {16'h0, tm.exists(ad_w) ? tm[ad_w] : 16'h0000});
  endtask
  // main sequence
  initial begin
    i = $urandom(32'h99d73626);
    repeat (2) @(posedge clk_i);
    {rst_i, cpg} <= 2'b01;
    poll(nvsc_pkg::ST_READY);
    chk(rc, 1);
    rreg(8'h14, q);
    chk(q, 32'h0);
    rreg(nvsc_pkg::REG_STATUS, q);
    chk(q & 32'h30, 32'h30);
    cmd(nvsc_pkg::CMD_HW_STORE);
    chk(st, 0);
    srd(18'h3FFFF);
    for (i = 0; i < 4; i++) begin
      ad = 18'($urandom) & 18'h1FFFF;
      swr(ad, 16'($urandom), 2'($urandom));
      srd(ad);
    end
    wreg(nvsc_pkg::REG_CMD, {29'h0, nvsc_pkg::CMD_HW_STORE});
    wreg(nvsc_pkg::REG_CMD, {29'h0, nvsc_pkg::CMD_READ});
    poll(nvsc_pkg::ST_DONE);
    es++;
    tn = tm;
    chk(st, es);
    chk(q & 32'h8, 32'h8);
    cmd(nvsc_pkg::CMD_SW_STORE);
    es++;
    chk(st, es);
    swr(ad, 16'($urandom), 2'b11);
    cmd(nvsc_pkg::CMD_SW_RECALL);
    er++;
    tm = tn;
    chk(rc, er);
    srd(ad);
    cmd(nvsc_pkg::CMD_AS_OFF);
    chk({31'h0, aen}, 32'h0);
    es++;
    chk(st, es);
    cmd(nvsc_pkg::CMD_AS_ON);
    chk({31'h0, aen}, 32'h1);
    es++;
    chk(st, es);
    @(posedge clk_i) iopg <= 1'b0;
    repeat (6) @(posedge clk_i);
    wreg(nvsc_pkg::REG_CMD, {29'h0, nvsc_pkg::CMD_READ});
    rreg(nvsc_pkg::REG_STATUS, q);
    chk(q & 32'h28, 32'h08);
    @(posedge clk_i) iopg <= 1'b1;
    poll(nvsc_pkg::ST_READY);
    wreg(nvsc_pkg::REG_CMD, 32'h0);
    rreg(nvsc_pkg::REG_STATUS, q);
    chk(q & 32'h8, 32'h8);
    swr(ad, 16'($urandom), 2'b11);
    @(posedge clk_i) cpg <= 1'b0;
    repeat (8) @(posedge clk_i);
    cpg <= 1'b1;
    es++;
    er++;
    poll(nvsc_pkg::ST_READY);
    chk(st, es);
    chk(rc, er);
    srd(ad);
    summarize();
  end
endmodule
